// ===== dv/rlsc_exc_model.sv
// exception logic model: entry on request, three-cycle return with pop
`timescale 1ns/1ps
`default_nettype none
module rlsc_exc_model (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic irq_req,
    input  wire logic ret_req,
    input  wire logic stacked_ra,
    input  wire logic irq_defer,
    output logic      exc_entry,
    output logic      exc_return_pop,
    output logic      popped_ra,
    output logic      return_from_interrupt_op_cycle3
);
    logic       pend_r;
    logic [1:0] step_r;
    // an entry waits while a stall is pending or running
    wire logic  take = (irq_req | pend_r) & ~irq_defer;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pend_r         <= 1'h0;
            step_r         <= 2'h0;
            exc_entry      <= 1'h0;
            exc_return_pop <= 1'h0;
            popped_ra      <= 1'h0;
            return_from_interrupt_op_cycle3  <= 1'h0;
        end else begin
            exc_entry      <= take;
            pend_r         <= (irq_req | pend_r) & ~take;
            step_r         <= ret_req ? 2'h1 : (step_r == 2'h0 ? 2'h0 : step_r + 2'h1);
            exc_return_pop <= (step_r == 2'h1);
            return_from_interrupt_op_cycle3  <= (step_r == 2'h2);
            if (step_r == 2'h1) begin
                popped_ra <= stacked_ra; // held through the third return cycle
            end
        end
    end
endmodule // rlsc_exc_model
`default_nettype wire

// ===== dv/tb_rlsc_ctrl.sv
// self-checking bench: register port, repeat loop, interrupts, stalls
`timescale 1ns/1ps
`default_nettype none
module tb_rlsc_ctrl;
    import rlsc_pkg::*;
    logic        clock = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, status_wr = 1'h0;
    logic [7:0]  reg_addr = 8'h00, status_wdata = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, exec_dst_ea = 16'h0000, reg_rdata, cpu_status_word;
    logic        exec_valid = 1'h0, exec_is_repeat = 1'h0, exec_rep_use_reg = 1'h0, pref_valid = 1'h0;
    logic [13:0] repeat_literal = 14'h0000, selected_working_register = 14'h0000;
    logic [3:0]  exec_dst_reg = 4'h0, pref_src_reg = 4'h0;
    logic [1:0]  exec_dst_mode = 2'h0, pref_src_mode = 2'h0;
    logic        pref_psv_access = 1'h0, irq_req = 1'h0, ret_req = 1'h0;
    logic        exc_entry, exc_return_pop, popped_ra, return_from_interrupt_op_cycle3, stacked_ra, repeat_active_flag;
    logic        pc_hold, fetch_inhibit, ds_addr_inhibit, stall_cycle, psv_extra_cycle, irq_defer;
    logic        prefetch_repeat;
    int          n_errors = 0, checked = 0, n;

    always #5 clock = ~clock;

    rlsc_ctrl i_dut (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .exec_valid,
        .exec_is_repeat, .exec_rep_use_reg, .repeat_literal, .selected_working_register, .exec_dst_reg,
        .exec_dst_mode, .exec_dst_ea, .pref_valid, .pref_src_reg, .pref_src_mode, .pref_psv_access,
        .exc_entry, .exc_return_pop, .popped_ra, .return_from_interrupt_op_cycle3, .status_wr, .status_wdata,
        .cpu_status_word, .stacked_ra, .repeat_active_flag, .pc_hold, .fetch_inhibit, .ds_addr_inhibit,
        .stall_cycle, .psv_extra_cycle, .irq_defer, .prefetch_repeat);
    rlsc_exc_model i_exc (.clock, .sys_rst, .irq_req, .ret_req, .stacked_ra, .irq_defer, .exc_entry,
        .exc_return_pop, .popped_ra, .return_from_interrupt_op_cycle3);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        checked++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clock);
        reg_addr <= a; reg_wdata <= v; reg_wr <= 1'h1;
        @(posedge clock);
        reg_wr <= 1'h0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        @(posedge clock);
        reg_addr <= a; reg_rd <= 1'h1;
        @(posedge clock);
        reg_rd <= 1'h0;
        #1 chk("register", e, reg_rdata);
    endtask
    // targets issued are plain moves, never flow changes or repeats
    task automatic rpt(input logic [13:0] c, input logic ur);
        @(posedge clock);
        exec_valid <= 1'h1; exec_is_repeat <= 1'h1; exec_rep_use_reg <= ur;
        repeat_literal <= ur ? 14'h0000 : c; selected_working_register <= ur ? c : 14'h0000;
        @(posedge clock);
        exec_is_repeat <= 1'h0;
        #1;
    endtask
    task automatic run(input int m, output int k);
        k = 0;
        while (repeat_active_flag === 1'h1 && k < m) begin
            chk("hold", 16'h7, {13'h0, pc_hold, fetch_inhibit, cpu_status_word[4]});
            k++;
            @(posedge clock);
            #1;
        end
    endtask
    task automatic irq(input int ek, input logic es);
        int k;
        k = 0;
        @(posedge clock);
        irq_req <= 1'h0; exec_valid <= 1'h0; pref_valid <= 1'h0;
        #1;
        while (exc_entry !== 1'h1 && k < 6) begin
            @(posedge clock);
            #1 k++;
        end
        chk("entry wait", 16'(ek), 16'(k));
        @(posedge clock);
        #1 chk("stacked", {14'h0, es, 1'h0}, {14'h0, stacked_ra, repeat_active_flag});
    endtask
    task automatic ret(input int ek);
        int k;
        k = 0;
        @(posedge clock);
        ret_req <= 1'h1;
        @(posedge clock);
        ret_req <= 1'h0;
        #1;
        while (prefetch_repeat !== 1'h1 && k < 4) begin
            @(posedge clock);
            #1 k++;
        end
        chk("prefetch", 16'(ek), 16'(k));
    endtask
    task automatic hz(input logic [3:0] dr, input logic [1:0] dm, input logic [15:0] ea, input logic [3:0] sr,
                      input logic [1:0] sm, input logic ps, input logic e, input logic p);
        @(posedge clock);
        irq_req <= 1'h0; exec_valid <= 1'h1; pref_valid <= 1'h1; exec_dst_reg <= dr; exec_dst_mode <= dm;
        exec_dst_ea <= ea; pref_src_reg <= sr; pref_src_mode <= sm; pref_psv_access <= ps;
        #1 chk("defer", {15'h0, e}, {15'h0, irq_defer});
        @(posedge clock);
        exec_valid <= 1'h0; pref_valid <= 1'h0;
        #1 chk("stall", {11'h0, e, e, e, e, 1'h0},
               {11'h0, stall_cycle, ds_addr_inhibit, fetch_inhibit, pc_hold, psv_extra_cycle});
        @(posedge clock);
        pref_psv_access <= 1'h0;
        #1 chk("window", {11'h0, 2'h0, p, p, p},
               {11'h0, stall_cycle, ds_addr_inhibit, fetch_inhibit, pc_hold, psv_extra_cycle});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4000) @(posedge clock);
        n_errors++;
        $display("watchdog expired");
        end_sim();
    end

    initial begin
        repeat (5) @(posedge clock);
        sys_rst <= 1'h0;
        rdc(8'h00, 16'h0000);
        rdc(8'h07, 16'h0000);
        wr(8'h00, 16'hffff);
        rdc(8'h00, 16'h3fff);
        wr(8'h01, 16'hffff);
        rdc(8'h01, 16'h0000);
        @(posedge clock);
        status_wr <= 1'h1; status_wdata <= 8'hff;
        @(posedge clock);
        status_wr <= 1'h0;
        #1 chk("status", 16'h00ef, cpu_status_word);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            rpt(i == 3 ? 14'h0005 : 14'(i), i[0]);
            run(20, n);
            chk("iterations", 16'(i == 3 ? 5 : i), 16'(n));
            @(posedge clock);
            exec_valid <= 1'h0;
            rdc(8'h00, 16'h0000);
        end
        $display("test repeat counts done");
        rpt(14'h0005, 1'h0);
        run(1, n);
        @(posedge clock);
        exec_valid <= 1'h0;
        @(posedge clock);
        irq_req <= 1'h1;
        irq(0, 1'h1);
        rdc(8'h01, 16'h0008);
        rdc(8'h00, 16'h0003);
        rpt(14'h0001, 1'h1);
        run(20, n);
        chk("nested", 16'h0001, 16'(n));
        @(posedge clock);
        exec_valid <= 1'h0;
        wr(8'h00, 16'h0003);
        ret(2);
        @(posedge clock);
        exec_valid <= 1'h1;
        #1 run(20, n);
        chk("resumed", 16'h0003, 16'(n));
        @(posedge clock);
        exec_valid <= 1'h0;
        $display("test interrupted loop done");
        rpt(14'h0005, 1'h0);
        run(1, n);
        @(posedge clock);
        exec_valid <= 1'h0;
        @(posedge clock);
        irq_req <= 1'h1;
        irq(0, 1'h1);
        wr(8'h00, 16'h0000);
        wr(8'h02, 16'h0000);
        rdc(8'h01, 16'h0000);
        ret(2);
        rdc(8'h01, 16'h0004);
        @(posedge clock);
        exec_valid <= 1'h1;
        #1 run(20, n);
        chk("early end", 16'h0000, 16'(n));
        @(posedge clock);
        exec_valid <= 1'h0;
        rdc(8'h00, 16'h0000);
        $display("test early end done");
        for (int dm = 0; dm < 4; dm++) begin
            for (int sm = 0; sm < 4; sm++) begin
                hz(4'h2, 2'(dm), 16'h0100, 4'h2, 2'(sm), 1'h0, (dm == 1 || dm == 3) && sm >= 2, 1'h0);
            end
        end
        for (int sm = 1; sm < 4; sm++) begin
            hz(4'h2, 2'h2, RLSC_WREG_MAP_BASE + 16'h0002 * RLSC_WREG_MAP_STEP, 4'h2, 2'(sm),
               1'h0, sm >= 2, 1'h0);
        end
        hz(4'h2, 2'h1, 16'h0100, 4'h3, 2'h2, 1'h0, 1'h0, 1'h0);
        $display("test hazard table done");
        @(posedge clock);
        irq_req <= 1'h1;
        hz(4'h2, 2'h1, 16'h0100, 4'h2, 2'h2, 1'h0, 1'h0, 1'h0);
        @(posedge clock);
        ret_req <= 1'h1;
        @(posedge clock);
        ret_req <= 1'h0;
        @(posedge clock);
        // second of the pair meets the last return cycle and must not stall
        hz(4'h2, 2'h1, 16'h0100, 4'h2, 2'h2, 1'h0, 1'h0, 1'h0);
        @(posedge clock);
        irq_req <= 1'h1; exec_valid <= 1'h1; pref_valid <= 1'h1; exec_dst_reg <= 4'h2; exec_dst_mode <= 2'h1;
        pref_src_reg <= 4'h2; pref_src_mode <= 2'h2;
        irq(2, 1'h0);
        ret(4);
        hz(4'h2, 2'h1, 16'h0100, 4'h2, 2'h2, 1'h1, 1'h1, 1'h1);
        $display("test stalls with interrupts done");
        end_sim();
    end
endmodule // tb_rlsc_ctrl
`default_nettype wire

// ===== rtl/rlsc_ctrl.sv
// repeat loop and read-after-write stall control, top level
// Summary of operation
// - repeat runs target count plus one times; count from literal or register
// - fourteen-bit repeat counter register loaded by the repeat instruction
// - non-zero loaded count sets repeat active flag, status bit four
// - repeat active flag is read-only to software status writes
// - program counter held while non-zero count is active
// - zero count acts as no-op, flag stays clear
// - no fetch while repeating; decrement per execution; clear at zero
// - loop interruptible; entry stacks flag with low status byte, then clears
// - return prefetches target in third cycle; popped flag resumes loop
// - window-reading target takes two cycles first after exception return
// - counter cleared in service routine ends loop early on return
// - stall one cycle when written register feeds next address calculation
// - stall when indirect write hits mapped register used as indirect source
// - during stall: write completes, no data addressing, pc hold, no fetch
// - stall belongs to following instruction, before its execution cycle
// - interrupt on first of pair: complete it, run second later unstalled
// - interrupt on second of pair: run with stall, then enter service
// - in a loop hazard compares the repeated instruction with itself
// - stall first, then one window cycle, then instruction cycle, never merged
`timescale 1ns/1ps
`default_nettype none
module rlsc_ctrl
    import rlsc_pkg::*;
#(
    parameter int unsigned CNT_W = RLSC_CNT_W
)(
    input  wire logic                        clock,
    input  wire logic                        sys_rst,
    // register port
    input  wire logic [rlsc_pkg::RLSC_ADDR_W-1:0] reg_addr,
    input  wire logic [rlsc_pkg::RLSC_DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic [rlsc_pkg::RLSC_DATA_W-1:0] reg_rdata,
    // decode stage: executing instruction
    input  wire logic                        exec_valid,
    input  wire logic                        exec_is_repeat,
    input  wire logic                        exec_rep_use_reg,
    input  wire logic [CNT_W-1:0]            repeat_literal,
    input  wire logic [CNT_W-1:0]            selected_working_register,
    input  wire logic [rlsc_pkg::RLSC_WREG_W-1:0] exec_dst_reg,
    input  wire logic [1:0]                  exec_dst_mode,
    input  wire logic [15:0]                 exec_dst_ea,
    // prefetched instruction
    input  wire logic                        pref_valid,
    input  wire logic [rlsc_pkg::RLSC_WREG_W-1:0] pref_src_reg,
    input  wire logic [1:0]                  pref_src_mode,
    input  wire logic                        pref_psv_access,
    // exception logic
    input  wire logic                        exc_entry,
    input  wire logic                        exc_return_pop,
    input  wire logic                        popped_ra,
    input  wire logic                        return_from_interrupt_op_cycle3,
    // status word software write (ra bit ignored)
    input  wire logic                        status_wr,
    input  wire logic [7:0]                  status_wdata,
    // outputs
    output logic [15:0]                      cpu_status_word,
    output logic                             stacked_ra,
    output logic                             repeat_active_flag,
    output logic                             pc_hold,
    output logic                             fetch_inhibit,
    output logic                             ds_addr_inhibit,
    output logic                             stall_cycle,
    output logic                             psv_extra_cycle,
    output logic                             irq_defer,
    output logic                             prefetch_repeat
);
    typedef enum logic [1:0] {
        RLSC_RUN,
        RLSC_STALL,
        RLSC_PSV
    } rlsc_state_e;

    ////////////////////////////////////////////////////////////////////////
    rlsc_state_e      state_r;
    rlsc_state_e      state_nxt;
    logic [CNT_W-1:0] repeat_loop_counter_r;
    logic [CNT_W-1:0] count_nxt;
    logic             ra_r;
    logic             ra_nxt;
    logic [7:0]       status_low_r;
    logic             first_after_ret_r;
    logic             in_isr_r;
    logic             stacked_ra_r;
    logic             suppress_stall_r;
    wire logic        hazard_raw;
    wire logic        hazard;
    wire logic        count_wr;
    wire logic        swctl_wr;
    wire logic [CNT_W-1:0] load_val;
    wire logic        rep_load;
    wire logic        rep_exec;
    wire logic        need_psv2;

    ////////////////////////////////////////////////////////////////////////
    rlsc_hazard u_hazard (
        .wr_reg      (exec_dst_reg),
        .wr_mode     (exec_dst_mode),
        .wr_valid    (exec_valid),
        .wr_ind_addr (exec_dst_ea),
        .rd_reg      (pref_src_reg),
        .rd_mode     (pref_src_mode),
        .rd_valid    (pref_valid),
        .hazard      (hazard_raw)
    );

    rlsc_regs u_regs (
        .clock       (clock),
        .sys_rst     (sys_rst),
        .reg_addr    (reg_addr),
        .reg_wr      (reg_wr),
        .reg_rd      (reg_rd),
        .count_val   (RLSC_CNT_W'(repeat_loop_counter_r)),
        .status_bits ({in_isr_r, first_after_ret_r, state_r == RLSC_STALL, ra_r}),
        .reg_rdata   (reg_rdata),
        .count_wr    (count_wr),
        .swctl_wr    (swctl_wr)
    );

    ////////////////////////////////////////////////////////////////////////
    // in a loop the prefetch never changes, so the same instruction is
    // checked against itself each iteration
    // the exception sequence gives the write time, so no stall after return
    assign hazard    = hazard_raw && !suppress_stall_r && !exc_entry;
    assign load_val  = exec_rep_use_reg ? selected_working_register : repeat_literal;
    assign rep_load  = exec_valid && exec_is_repeat && (state_r == RLSC_RUN);
    assign rep_exec  = exec_valid && ra_r && !exec_is_repeat && (state_r == RLSC_RUN);
    assign need_psv2 = pref_psv_access && first_after_ret_r;

    // stall, then window cycle, then the instruction itself
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            RLSC_RUN: begin
                if (hazard) begin
                    state_nxt = RLSC_STALL;
                end else if (need_psv2) begin
                    state_nxt = RLSC_PSV;
                end
            end
            RLSC_STALL: begin
                state_nxt = need_psv2 ? RLSC_PSV : RLSC_RUN;
            end
            RLSC_PSV: begin
                state_nxt = RLSC_RUN;
            end
            default: begin
                state_nxt = RLSC_RUN;
            end
        endcase
    end

    always_comb begin
        count_nxt = repeat_loop_counter_r;
        ra_nxt    = ra_r;
        if (rep_load) begin
            count_nxt = load_val;
            ra_nxt    = (load_val != '0);
        end else if (exc_entry) begin
            ra_nxt    = 1'b0;
        end else if (exc_return_pop) begin
            // a counter zeroed by the service routine ends the loop here
            ra_nxt    = popped_ra && (repeat_loop_counter_r != '0);
        end else if (rep_exec) begin
            count_nxt = CNT_W'(repeat_loop_counter_r - 1'b1);
            ra_nxt    = (repeat_loop_counter_r != CNT_W'(1));
        end
        // software write to the counter loses to a repeat load
        if (count_wr && !rep_load) begin
            count_nxt = CNT_W'(reg_wdata);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_r               <= RLSC_RUN;
            repeat_loop_counter_r <= CNT_W'(RLSC_CNT_RST);
            ra_r                  <= 1'b0;
        end else begin
            state_r               <= state_nxt;
            repeat_loop_counter_r <= count_nxt;
            ra_r                  <= ra_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            status_low_r <= 8'h00;
        end else if (status_wr) begin
            status_low_r <= status_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stacked_ra_r <= 1'b0;
        end else if (exc_entry) begin
            stacked_ra_r <= ra_r;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            first_after_ret_r <= 1'b0;
        end else if (exc_return_pop) begin
            first_after_ret_r <= 1'b1;
        // a stalled prefetch has not run yet, so its window cycle is still owed
        end else if (psv_extra_cycle || (exec_valid && state_r == RLSC_RUN && !hazard)) begin
            first_after_ret_r <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            suppress_stall_r <= 1'b0;
        end else begin
            suppress_stall_r <= exc_return_pop;
        end
    end

    // software may flag service-routine context; cleared by return
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            in_isr_r <= 1'b0;
        end else if (exc_entry) begin
            in_isr_r <= 1'b1;
        end else if (exc_return_pop) begin
            in_isr_r <= 1'b0;
        end else if (swctl_wr) begin
            in_isr_r <= reg_wdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign repeat_active_flag = ra_r;
    assign stacked_ra         = stacked_ra_r;
    assign cpu_status_word    = {8'h00, status_low_r[7:5], ra_r, status_low_r[3:0]};
    assign stall_cycle        = (state_r == RLSC_STALL);
    assign psv_extra_cycle    = (state_r == RLSC_PSV);
    assign pc_hold            = ra_r || stall_cycle || psv_extra_cycle;
    assign fetch_inhibit      = ra_r || stall_cycle || psv_extra_cycle;
    assign ds_addr_inhibit    = stall_cycle;
    // an interrupt waits while a stall is pending
    assign irq_defer          = stall_cycle || (state_r == RLSC_RUN && hazard);
    assign prefetch_repeat    = return_from_interrupt_op_cycle3 && popped_ra;

    ////////////////////////////////////////////////////////////////////////
    a_zero_load_clear: assert property (@(posedge clock) disable iff (sys_rst)
        rep_load && load_val == '0 |=> !repeat_active_flag) else $error("zero count set flag");
    a_load_sets_flag: assert property (@(posedge clock) disable iff (sys_rst)
        rep_load && load_val != '0 |=> repeat_active_flag && repeat_loop_counter_r == $past(load_val))
        else $error("non-zero load failed");
    a_count_decr: assert property (@(posedge clock) disable iff (sys_rst)
        rep_exec && !exc_entry && !exc_return_pop && !count_wr |=>
        repeat_loop_counter_r == CNT_W'($past(repeat_loop_counter_r) - 1'b1)) else $error("no decrement");
    a_flag_ro: assert property (@(posedge clock) disable iff (sys_rst)
        status_wr && !rep_load && !rep_exec && !exc_entry && !exc_return_pop |=> $stable(repeat_active_flag))
        else $error("software changed flag");
    a_entry_clears: assert property (@(posedge clock) disable iff (sys_rst)
        exc_entry && !rep_load |=> !repeat_active_flag && stacked_ra == $past(repeat_active_flag))
        else $error("entry did not stack and clear");
    a_stall_one: assert property (@(posedge clock) disable iff (sys_rst)
        stall_cycle |=> !stall_cycle) else $error("stall longer than one cycle");
    a_hazard_stall: assert property (@(posedge clock) disable iff (sys_rst)
        state_r == RLSC_RUN && hazard |=> stall_cycle && pc_hold && fetch_inhibit && ds_addr_inhibit)
        else $error("hazard without stall");
    a_stall_psv_order: assert property (@(posedge clock) disable iff (sys_rst)
        stall_cycle && need_psv2 |=> psv_extra_cycle ##1 !psv_extra_cycle) else $error("stall psv order");
    a_early_end: assert property (@(posedge clock) disable iff (sys_rst)
        exc_return_pop && !rep_load && !exc_entry && repeat_loop_counter_r == '0 |=> !repeat_active_flag)
        else $error("zeroed loop resumed");
    a_ret_no_stall: assert property (@(posedge clock) disable iff (sys_rst)
        exc_return_pop && state_r == RLSC_RUN ##1 state_r == RLSC_RUN |=> !stall_cycle)
        else $error("stall after return");
endmodule // rlsc_ctrl
`default_nettype wire

// ===== rtl/rlsc_hazard.sv
// read-after-write hazard detector for address generation
`timescale 1ns/1ps
`default_nettype none
module rlsc_hazard
    import rlsc_pkg::*;
(
    input  wire logic [RLSC_WREG_W-1:0] wr_reg,
    input  wire logic [1:0]             wr_mode,
    input  wire logic                   wr_valid,
    input  wire logic [15:0]            wr_ind_addr,
    input  wire logic [RLSC_WREG_W-1:0] rd_reg,
    input  wire logic [1:0]             rd_mode,
    input  wire logic                   rd_valid,
    output logic                        hazard
);
    // memory-mapped location of the read register
    wire logic [15:0] rd_map_addr;
    wire logic        same_reg;
    wire logic        rd_uses_ea;
    wire logic        wr_modifies;
    wire logic        mapped_hit;

    assign rd_map_addr = 16'(RLSC_WREG_MAP_BASE + RLSC_WREG_MAP_STEP * 16'(rd_reg));
    assign same_reg    = (wr_reg == rd_reg);
    assign rd_uses_ea  = (rd_mode == RLSC_AM_IND) || (rd_mode == RLSC_AM_IND_MOD);
    assign wr_modifies = (wr_mode == RLSC_AM_DIRECT) || (wr_mode == RLSC_AM_IND_MOD);
    // indirect write landing on the register's own mapped word
    assign mapped_hit  = (wr_mode == RLSC_AM_IND) && (wr_ind_addr == rd_map_addr) && rd_uses_ea;
    assign hazard      = wr_valid && rd_valid
                         && ((same_reg && wr_modifies && rd_uses_ea) || mapped_hit);
endmodule // rlsc_hazard
`default_nettype wire

// ===== rtl/rlsc_pkg.sv
// shared constants for the repeat loop and stall control block
package rlsc_pkg;
    localparam int unsigned RLSC_CNT_W      = 14;
    localparam int unsigned RLSC_WREG_W     = 4;
    localparam int unsigned RLSC_ADDR_W     = 8;
    localparam int unsigned RLSC_DATA_W     = 16;
    localparam logic [3:0]  RLSC_RA_BIT     = 4'h4;
    localparam logic [13:0] RLSC_CNT_RST    = 14'h0000;
    localparam logic [15:0] RLSC_WREG_MAP_BASE = 16'h0000;
    localparam logic [15:0] RLSC_WREG_MAP_STEP = 16'h0002;
    // register offsets of the plain register port
    localparam logic [7:0]  RLSC_OFS_COUNT  = 8'h00;
    localparam logic [7:0]  RLSC_OFS_STATUS = 8'h01;
    localparam logic [7:0]  RLSC_OFS_SWCTL  = 8'h02;
    // status read bits
    localparam int unsigned RLSC_ST_RA      = 0;
    localparam int unsigned RLSC_ST_STALL   = 1;
    localparam int unsigned RLSC_ST_PSVX    = 2;
    localparam int unsigned RLSC_ST_ISRSW   = 3;
    // addressing modes of a working register operand
    typedef enum logic [1:0] {
        RLSC_AM_NONE,
        RLSC_AM_DIRECT,
        RLSC_AM_IND,
        RLSC_AM_IND_MOD
    } rlsc_am_e;
endpackage : rlsc_pkg

// ===== rtl/rlsc_regs.sv
// register port: repeat counter, status view, software control
`timescale 1ns/1ps
`default_nettype none
module rlsc_regs
    import rlsc_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   sys_rst,
    input  wire logic [RLSC_ADDR_W-1:0] reg_addr,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [RLSC_CNT_W-1:0]  count_val,
    input  wire logic [3:0]             status_bits,
    output logic [RLSC_DATA_W-1:0]      reg_rdata,
    output logic                        count_wr,
    output logic                        swctl_wr
);
    wire logic                   sel_count;
    wire logic                   sel_status;
    wire logic [RLSC_DATA_W-1:0] rd_mux;
    logic [RLSC_DATA_W-1:0]      reg_rdata_r;

    assign sel_count  = (reg_addr == RLSC_OFS_COUNT);
    assign sel_status = (reg_addr == RLSC_OFS_STATUS);
    assign count_wr   = reg_wr && sel_count;
    assign swctl_wr   = reg_wr && (reg_addr == RLSC_OFS_SWCTL);
    // unmapped offsets read zero
    assign rd_mux = sel_count  ? {{(RLSC_DATA_W-RLSC_CNT_W){1'b0}}, count_val} :
                    sel_status ? {{(RLSC_DATA_W-4){1'b0}}, status_bits} :
                    {RLSC_DATA_W{1'b0}};

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata_r <= 16'h0000;
        end else begin
            reg_rdata_r <= reg_rd ? rd_mux : 16'h0000;
        end
    end
    assign reg_rdata = reg_rdata_r;
endmodule // rlsc_regs
`default_nettype wire
